// ==== rtl/hps_pkg.sv ====
/*
  Constants for the host port strobe and ready logic: access-select codes,
  pin bit positions, reset values and the read-data lead count.
  Assumes a 100 MHz CPU clock and a single clock domain.
*/
// Summary of operation
// R1: Strobe is not(strobe one xor two) or select
// R2: Ready forced low while chip select high
// R3: Ready high at select fall while busy
// R4: First read half fetches; busy until loaded
// R5: Ready high after second half strobe rise, except for fixed-address reads
// R6: Other accesses keep ready low throughout
// R7: Control and pointer accesses never touch ready
// R8: Host pulses address latch once per strobe
// R9: Unused address latch: selects taken at strobe
// R10: Read data valid two clocks before ready
// R11: Drive data bus only during read strobe
// R12: Host holds strobe until ready goes low
// R13: Host presents access, direction, half selects
// R14: Pins synchronised before any edge detection
// R15: Internal transfer starts after second half
package hps_pkg;
  // Access-select codes
  localparam logic [1:0] ACC_CONTROL    = 2'h0;
  localparam logic [1:0] ACC_DATA_AUTO  = 2'h1;
  localparam logic [1:0] ACC_POINTER    = 2'h2;
  localparam logic [1:0] ACC_DATA_FIXED = 2'h3;
  // Bit positions in the synchronised pin vector
  localparam int PIN_CS   = 0;
  localparam int PIN_DS1  = 1;
  localparam int PIN_DS2  = 2;
  localparam int PIN_ALS  = 3;
  localparam int PIN_ACC  = 4;
  localparam int PIN_RW   = 6;
  localparam int PIN_HW   = 7;
  localparam int PIN_DAT  = 8;
  localparam int PIN_W    = 24;
  // Reset values
  localparam logic READY_N_RST = 1'b0;
  localparam logic OE_N_RST    = 1'b1;
  // Read data lead ahead of ready: 2P - 4 ns, a least time
  localparam int CLK_PERIOD_NS  = 10;
  localparam int LEAD_MARGIN_NS = 4;
  localparam int DATA_LEAD_NS   = 2 * CLK_PERIOD_NS - LEAD_MARGIN_NS;
  localparam logic [1:0] LEAD_CYC = 2'((DATA_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : hps_pkg

// ==== rtl/hps_strobe_ready.sv ====
/*
  Strobe decode and ready handshake of the 16-bit host port, with the
  data-window register and the request path to the internal DMA engine.
  Assumes the DMA engine runs on CLK and answers each request once.
*/
`timescale 1ns/1ps
module hps_strobe_ready (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        PORT_CHIP_SELECT_N,
  input  wire logic        DATA_STROBE_ONE,
  input  wire logic        DATA_STROBE_TWO,
  input  wire logic        ADDRESS_LATCH_STROBE_N,
  input  wire logic [1:0]  ACCESS_SELECT,
  input  wire logic        READ_WRITE_SELECT,
  input  wire logic        HALF_WORD_SELECT,
  input  wire logic [15:0] HOST_DATA_BUS,
  output logic      [15:0] HOST_DATA_DRIVE,
  output logic             HOST_DATA_OE_N,
  output logic             PORT_READY_N,
  input  wire logic [15:0] REG_READ_DATA,
  output logic             DMA_FETCH_REQ,
  output logic             DMA_STORE_REQ,
  output logic             DMA_AUTO_INC,
  output logic      [31:0] DMA_WRITE_DATA,
  input  wire logic [31:0] DMA_READ_DATA,
  input  wire logic        DMA_READ_VALID,
  input  wire logic        DMA_DONE
);
  // Raw pins gathered so one loop synchronises them all
  logic [hps_pkg::PIN_W-1:0] pins_raw;
  logic [hps_pkg::PIN_W-1:0] sync1_q;   // First stage, read only by stage two
  logic [hps_pkg::PIN_W-1:0] sync2_q;   // Safe copies

  assign pins_raw = {HOST_DATA_BUS, HALF_WORD_SELECT, READ_WRITE_SELECT, ACCESS_SELECT,
                     ADDRESS_LATCH_STROBE_N, DATA_STROBE_TWO, DATA_STROBE_ONE, PORT_CHIP_SELECT_N};

  // Two-flop synchroniser per pin bit
  genvar gi;
  generate
    for (gi = 0; gi < hps_pkg::PIN_W; gi++) begin : g_sync
      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
        end else begin
          sync1_q[gi] <= pins_raw[gi];   // R14
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // Decoded views of the synchronised pins
  logic        cs_n;
  logic        als_n;
  logic [3:0]  sel_now;                // {half, rw, access}
  logic [15:0] din;
  logic        stb_now_n;
  assign cs_n      = sync2_q[hps_pkg::PIN_CS];
  assign als_n     = sync2_q[hps_pkg::PIN_ALS];
  assign sel_now   = sync2_q[hps_pkg::PIN_HW:hps_pkg::PIN_ACC];
  assign din       = sync2_q[hps_pkg::PIN_DAT +: 16];
  // Combined strobe: active only while chip select is low
  assign stb_now_n = ~(sync2_q[hps_pkg::PIN_DS1] ^ sync2_q[hps_pkg::PIN_DS2]) | cs_n;   // R1

  // State registers
  logic        stb_q, stb_d;           // Previous combined strobe
  logic        als_q, als_d;           // Previous address latch strobe
  logic        lat_v_q, lat_v_d;       // Selects latched by address strobe
  logic [3:0]  lat_sel_q, lat_sel_d;
  logic [3:0]  acc_q, acc_d;           // Selects of the current access
  logic        act_q, act_d;           // Strobe active
  logic [15:0] wlo_q, wlo_d;           // First write half-word
  logic [15:0] whold_q, whold_d;       // Host data tracked while strobe low
  logic [31:0] dw_q, dw_d;             // Data window register
  logic        have_q, have_d;         // Data window holds unread fetched word
  logic        fpend_q, fpend_d;       // Fetch outstanding
  logic        spend_q, spend_d;       // Store outstanding
  logic        wait_q, wait_d;         // Read waiting for the data window
  logic [1:0]  lead_q, lead_d;         // Data lead countdown before ready
  logic        rdy_q, rdy_d;
  logic        oe_q, oe_d;
  logic [15:0] dout_q, dout_d;
  logic        freq_q, freq_d;
  logic        sreq_q, sreq_d;
  logic        inc_q, inc_d;
  logic [31:0] wdat_q, wdat_d;

  // Edges and the access view at the strobe fall
  logic       stb_fall, stb_rise, als_fall;
  logic [3:0] sel_take;
  logic       is_data, is_read, is_second;
  assign stb_fall  = stb_q & ~stb_now_n;   // R14
  assign stb_rise  = ~stb_q & stb_now_n;
  assign als_fall  = als_q & ~als_n;
  // Unused address strobe stays high, so selects come with the strobe
  assign sel_take  = lat_v_q ? lat_sel_q : sel_now;   // R9
  assign is_data   = (acc_q[1:0] == hps_pkg::ACC_DATA_AUTO) || (acc_q[1:0] == hps_pkg::ACC_DATA_FIXED);
  assign is_read   = acc_q[2];
  assign is_second = acc_q[3];

  // Next-state logic for the whole handshake
  always_comb begin
    stb_d     = stb_now_n;
    als_d     = als_n;
    lat_v_d   = lat_v_q;
    lat_sel_d = lat_sel_q;
    acc_d     = acc_q;
    act_d     = act_q;
    wlo_d     = wlo_q;
    whold_d   = whold_q;
    dw_d      = dw_q;
    have_d    = have_q;
    fpend_d   = fpend_q;
    spend_d   = spend_q;
    wait_d    = wait_q;
    lead_d    = (lead_q != 2'h0) ? lead_q - 2'h1 : 2'h0;
    freq_d    = 1'b0;
    sreq_d    = 1'b0;
    inc_d     = inc_q;
    wdat_d    = wdat_q;
    // Address strobe latches selects once per strobe period
    if (als_fall && !lat_v_q) begin
      lat_v_d   = 1'b1;
      lat_sel_d = sel_now;
    end
    // Host data tracked while the strobe is low; held at the rise
    if (!stb_now_n) begin
      whold_d = din;
    end
    if (stb_fall) begin
      act_d = 1'b1;
      acc_d = sel_take;
      // First half of a data-window read needs the word in the window
      if (sel_take[2] && !sel_take[3] &&
          (sel_take[1:0] == hps_pkg::ACC_DATA_AUTO || sel_take[1:0] == hps_pkg::ACC_DATA_FIXED)) begin
        wait_d = 1'b1;   // R4
        inc_d  = (sel_take[1:0] == hps_pkg::ACC_DATA_AUTO);
        if (!have_q && !fpend_q) begin
          freq_d  = 1'b1;   // R4
          fpend_d = 1'b1;
        end
      end
    end
    // Store answer clears first, so a new store in the same cycle stays pending
    if (DMA_DONE) begin
      spend_d = 1'b0;
    end
    // Strobe rise ends the access; control and pointer accesses stop here
    if (stb_rise) begin
      act_d   = 1'b0;
      lat_v_d = 1'b0;
      if (act_q && is_data) begin
        if (!is_read && !is_second) begin
          wlo_d = whold_q;   // R15
        end else if (!is_read && is_second) begin
          wdat_d  = {whold_q, wlo_q};   // R15
          sreq_d  = 1'b1;   // R5
          spend_d = 1'b1;
          have_d  = 1'b0;
          inc_d   = (acc_q[1:0] == hps_pkg::ACC_DATA_AUTO);
        end else if (is_second && acc_q[1:0] == hps_pkg::ACC_DATA_AUTO) begin
          freq_d  = 1'b1;   // R5
          fpend_d = 1'b1;
          inc_d   = 1'b1;
        end
      end
    end
    // Window consumed by a waiting read, then data leads ready
    if (wait_q && have_q && !fpend_q) begin
      wait_d = 1'b0;
      have_d = 1'b0;
      lead_d = hps_pkg::LEAD_CYC;   // R10
    end
    // Arrival wins over a consume in the same cycle
    if (DMA_READ_VALID) begin
      dw_d    = DMA_READ_DATA;   // R4
      have_d  = 1'b1;
      fpend_d = freq_d;   // A request raised in this cycle stays pending
    end
    // Busy terms come only from data-window transfers
    rdy_d  = cs_n ? 1'b0 : (spend_q | fpend_q | wait_q | (lead_q != 2'h0));   // R2 R3 R6 R7
    // Drive only during an active read strobe
    oe_d   = !stb_now_n && (stb_fall ? sel_take[2] : (act_q && is_read));   // R11
    dout_d = is_data ? (is_second ? dw_q[31:16] : dw_q[15:0]) : REG_READ_DATA;
  end

  // Register stage
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      stb_q     <= 1'b1;
      als_q     <= 1'b1;
      lat_v_q   <= 1'b0;
      lat_sel_q <= 4'h0;
      acc_q     <= 4'h0;
      act_q     <= 1'b0;
      wlo_q     <= 16'h0;
      whold_q   <= 16'h0;
      dw_q      <= 32'h0;
      have_q    <= 1'b0;
      fpend_q   <= 1'b0;
      spend_q   <= 1'b0;
      wait_q    <= 1'b0;
      lead_q    <= 2'h0;
      rdy_q     <= hps_pkg::READY_N_RST;
      oe_q      <= 1'b0;
      dout_q    <= 16'h0;
      freq_q    <= 1'b0;
      sreq_q    <= 1'b0;
      inc_q     <= 1'b0;
      wdat_q    <= 32'h0;
    end else begin
      stb_q     <= stb_d;
      als_q     <= als_d;
      lat_v_q   <= lat_v_d;
      lat_sel_q <= lat_sel_d;
      acc_q     <= acc_d;
      act_q     <= act_d;
      wlo_q     <= wlo_d;
      whold_q   <= whold_d;
      dw_q      <= dw_d;
      have_q    <= have_d;
      fpend_q   <= fpend_d;
      spend_q   <= spend_d;
      wait_q    <= wait_d;
      lead_q    <= lead_d;
      rdy_q     <= rdy_d;
      oe_q      <= oe_d;
      dout_q    <= dout_d;
      freq_q    <= freq_d;
      sreq_q    <= sreq_d;
      inc_q     <= inc_d;
      wdat_q    <= wdat_d;
    end
  end

  // Outputs straight from flops; enable is active low
  assign PORT_READY_N   = rdy_q;
  assign HOST_DATA_OE_N = ~oe_q;
  assign HOST_DATA_DRIVE = dout_q;
  assign DMA_FETCH_REQ  = freq_q;
  assign DMA_STORE_REQ  = sreq_q;
  assign DMA_AUTO_INC   = inc_q;
  assign DMA_WRITE_DATA = wdat_q;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_second_write_rise;
    stb_rise && act_q && is_data && !is_read && is_second;
  endsequence

  chk_strobe_decode: assert property (stb_now_n == (~($past(DATA_STROBE_ONE, 2) ^ $past(DATA_STROBE_TWO, 2)) // R1
                                      | $past(PORT_CHIP_SELECT_N, 2)))
    else $error("combined strobe not decoded from pins");
  chk_select_gates_ready: assert property (cs_n |=> !rdy_q) // R2
    else $error("ready high while chip select high");
  chk_busy_at_select: assert property ($fell(cs_n) && spend_q && !DMA_DONE |=> rdy_q) // R3
    else $error("ready not busy at select fall");
  chk_read_fetch: assert property (stb_fall && sel_take[2] && !sel_take[3] && sel_take[0] && !have_q // R4
                                   && !fpend_q |=> freq_q ##1 (rdy_q || cs_n))
    else $error("first read half did not fetch");
  chk_write_busy: assert property (s_second_write_rise |=> sreq_q ##1 (rdy_q || cs_n || DMA_DONE)) // R5
    else $error("second write half not busy");
  chk_plain_access: assert property (stb_fall && !sel_take[0] && !spend_q && !fpend_q && !wait_q // R6 R7
                                     && lead_q == 2'h0 |=> !rdy_q ##1 !rdy_q)
    else $error("ready high during control or pointer access");
  chk_latched_select: assert property (stb_fall && !lat_v_q |=> acc_q == $past(sel_now)) // R9
    else $error("select not taken with strobe");
  chk_data_lead: assert property ($fell(rdy_q) && oe_q && is_data && is_read // R10
                                  |-> $past(dout_q, 2) == dout_q && $past(oe_q, 2))
    else $error("read data lead too short");
  chk_drive_window: assert property (oe_q |-> $past(!stb_now_n)) // R11
    else $error("bus driven outside read strobe");
  chk_store_pair: assert property (sreq_q |-> wdat_q[15:0] == wlo_q) // R15
    else $error("store word not paired");
endmodule : hps_strobe_ready

// ==== test/hps_dma_model.sv ====
/*
  Behavioural model of the internal DMA engine behind the host port.
  Assumes one-cycle request pulses on CLK and a single clock domain.
*/
`timescale 1ns/1ps
module hps_dma_model (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        FETCH_REQ,
  input  wire logic        STORE_REQ,
  input  wire logic [31:0] FETCH_WORD,
  input  wire logic [7:0]  DELAY,
  output logic      [31:0] READ_DATA,
  output logic             READ_VALID,
  output logic             DONE
);
  int f_cnt = 0;  // Cycles left before the fetch answer
  int s_cnt = 0;  // Cycles left before the store answer
  initial begin
    READ_DATA  = 32'h0;
    READ_VALID = 1'b0;
    DONE       = 1'b0;
  end
  // Answer DELAY+1 cycles after a request; stale data flips every cycle
  always @(posedge CLK) begin
    READ_VALID <= RESETN && (f_cnt == 1);
    DONE       <= RESETN && (s_cnt == 1);
    READ_DATA  <= (f_cnt == 1) ? FETCH_WORD : ~READ_DATA;
    f_cnt <= !RESETN ? 0 : FETCH_REQ ? int'(DELAY) + 1 : (f_cnt > 0 ? f_cnt - 1 : 0);
    s_cnt <= !RESETN ? 0 : STORE_REQ ? int'(DELAY) + 1 : (s_cnt > 0 ? s_cnt - 1 : 0);
  end
endmodule : hps_dma_model

// ==== test/tb_top.sv ====
/*
  Self-checking bench for the host port strobe and ready logic.
  Assumes a DMA model answering requests and a host that waits for ready.
*/
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0, resetn = 1'b0, cs_n = 1'b1, ds1 = 1'b1, ds2 = 1'b1;
  logic        als_n = 1'b1, rw = 1'b0, hw = 1'b0;
  logic [1:0]  acc_sel = 2'h0;
  logic [15:0] din = 16'h0, reg_rd = 16'h0, dout, bus;
  logic        oe_n, rdy_n, f_req, s_req, r_val, done, auto_inc;
  logic [31:0] wdata, rdata, st_data, f_word = 32'h0;
  logic [7:0]  delay = 8'h02;
  int          mismatches = 0, checks = 0, stores = 0, fetches = 0;
  always #5 clk = ~clk;
  // Wire level: device drives while its enable is low
  assign bus = !oe_n ? dout : din;
  hps_strobe_ready hps_strobe_ready_i (.CLK(clk), .RESETN(resetn), .PORT_CHIP_SELECT_N(cs_n),
    .DATA_STROBE_ONE(ds1), .DATA_STROBE_TWO(ds2), .ADDRESS_LATCH_STROBE_N(als_n),
    .ACCESS_SELECT(acc_sel), .READ_WRITE_SELECT(rw), .HALF_WORD_SELECT(hw), .HOST_DATA_BUS(bus),
    .HOST_DATA_DRIVE(dout), .HOST_DATA_OE_N(oe_n), .PORT_READY_N(rdy_n), .REG_READ_DATA(reg_rd),
    .DMA_FETCH_REQ(f_req), .DMA_STORE_REQ(s_req), .DMA_AUTO_INC(auto_inc), .DMA_WRITE_DATA(wdata),
    .DMA_READ_DATA(rdata), .DMA_READ_VALID(r_val), .DMA_DONE(done));
  hps_dma_model hps_dma_model_i (.CLK(clk), .RESETN(resetn), .FETCH_REQ(f_req), .STORE_REQ(s_req),
    .FETCH_WORD(f_word), .DELAY(delay), .READ_DATA(rdata), .READ_VALID(r_val), .DONE(done));
  // Count request pulses away from the edge that launches them
  always @(negedge clk) begin
    if (s_req === 1'b1) begin
      stores++;
      st_data = wdata;
    end
    if (f_req === 1'b1) fetches++;
  end
  task automatic give_verdict();
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp1(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask : cmp1
  // One strobe period; bl reports ready seen busy while strobe active
  task automatic acc(input logic [1:0] sel, input logic r, h, two, als, input logic [15:0] wd,
                     output logic [15:0] rd, output logic bl);
    logic [15:0] p1, p2;
    int          n;
    bl = 1'b0;
    @(posedge clk);
    acc_sel <= sel; rw <= r; hw <= h; din <= wd; als_n <= ~als;
    @(posedge clk);
    if (als) acc_sel <= sel ^ 2'h3;
    if (two) ds2 <= 1'b0; else ds1 <= 1'b0;
    p1 = dout;
    p2 = dout;
    for (n = 0; n < 80; n++) begin
      @(posedge clk);
      if (n == 2) als_n <= 1'b1;
      #1;
      bl |= (rdy_n === 1'b1);
      if (n > 6 && rdy_n === 1'b0) break;
      p2 = p1;
      p1 = dout;
    end
    if (n == 80) begin
      mismatches++;
      give_verdict();
    end
    if (bl) cmp({16'h0, p2}, {16'h0, dout});
    cmp1(oe_n, ~r);
    rd = dout;
    @(posedge clk);
    ds1 <= 1'b1;
    ds2 <= 1'b1;
  endtask : acc
  // Strobe high between accesses; bh reports ready seen busy
  task automatic gap(output logic bh);
    int n;
    bh = 1'b0;
    for (n = 0; n < 80; n++) begin
      @(posedge clk);
      #1;
      bh |= (rdy_n === 1'b1);
      if (n > 5 && rdy_n === 1'b0) break;
    end
    if (n == 80) begin
      mismatches++;
      give_verdict();
    end
  endtask : gap
  task automatic s_write();
    logic [15:0] rd;
    logic        b;
    int          s0;
    s0 = stores;
    acc(2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 16'h1234, rd, b);
    gap(b); cmp(32'(stores - s0), 32'h0);
    acc(2'h3, 1'b0, 1'b1, 1'b1, 1'b0, 16'habcd, rd, b);
    gap(b); cmp1(b, 1'b1);
    cmp(32'(stores - s0), 32'h1);
    cmp(st_data, 32'habcd1234);
  endtask : s_write
  task automatic s_read();
    logic [15:0] rd;
    logic        b;
    int          f0;
    f_word <= 32'h5a5ac3c3;
    f0 = fetches;
    acc(2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0, rd, b); cmp1(b, 1'b1);
    cmp({16'h0, rd}, 32'hc3c3); cmp(32'(fetches - f0), 32'h1);
    cmp1(auto_inc, 1'b0);
    gap(b); cmp1(oe_n, 1'b1);
    acc(2'h3, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0, rd, b); cmp1(b, 1'b0);
    cmp({16'h0, rd}, 32'h5a5a);
    gap(b); cmp1(b, 1'b0);
    f_word <= 32'h00ffee11;
    acc(2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0, rd, b); cmp1(b, 1'b1);
    cmp({16'h0, rd}, 32'hee11);
    cmp1(auto_inc, 1'b1);
    gap(b);
    acc(2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0, rd, b); cmp({16'h0, rd}, 32'h00ff);
    gap(b); cmp1(b, 1'b1);
  endtask : s_read
  task automatic s_ctrl();
    logic [15:0] rd;
    logic        b;
    @(posedge clk);
    reg_rd <= 16'h0f0e;
    acc(2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0, rd, b); cmp1(b, 1'b0);
    cmp({16'h0, rd}, 32'h0f0e);
    gap(b); cmp1(b, 1'b0);
    acc(2'h2, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0042, rd, b); cmp1(b, 1'b0);
    gap(b); cmp1(b, 1'b0);
    acc(2'h0, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0, rd, b); cmp1(b, 1'b0);
    cmp({16'h0, rd}, 32'h0f0e);
    gap(b);
  endtask : s_ctrl
  // Slow store; chip select toggled while it is pending
  task automatic s_busy();
    logic [15:0] rd;
    logic        b;
    delay <= 8'h1e;
    acc(2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 16'h5555, rd, b);
    gap(b);
    acc(2'h3, 1'b0, 1'b1, 1'b0, 1'b0, 16'haaaa, rd, b);
    @(posedge clk);
    cs_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1; cmp1(rdy_n, 1'b0);
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1; cmp1(rdy_n, 1'b1);
    gap(b); cmp1(rdy_n, 1'b0);
  endtask : s_busy
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    cs_n <= 1'b0;
    s_write();
    s_read();
    s_ctrl();
    s_busy();
    give_verdict();
  end
endmodule : tb_top
